// file: src/vpsc_ctrl.sv
/*
  Variable fine phase shift controller: takes step requests on the
  control clock, keeps the signed step count and pulses completion.
  Assumes control and reference clocks below 62.5 MHz, sampled here.
*/
`timescale 1ns/1ps
module vpsc_ctrl
  import vpsc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        shift_ctrl_clock_i,
  input  wire logic        reference_clock_in_i,
  input  wire logic        shift_request_enable_i,
  input  wire logic        shift_direction_i,
  output logic             shift_complete_o,
  output logic signed [15:0] phase_step_count_o
);
  typedef struct packed {
    vpsc_state_e        st;
    logic [6:0]         ref_cnt;
    logic [1:0]         ctl_cnt;
    logic signed [15:0] count;
    logic               done;
    logic [15:0]        period;
    logic [15:0]        limit;
    logic               ack;
    logic [31:0]        rdata;
  } vpsc_state_s;

  vpsc_state_s q;
  vpsc_state_s next_q;

  vpsc_edge_if #(.W(4), .NCLK(2)) edges ();

  // bit 0 control clock, bit 1 reference clock
  vpsc_sync #(.W(4), .NCLK(2)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({shift_direction_i, shift_request_enable_i,
               reference_clock_in_i, shift_ctrl_clock_i}),
    .edge_o  (edges)
  );

  logic ctl_rise;
  logic ref_rise;
  logic req_en;
  logic req_inc;
  logic can_take;
  logic bus_req;
  logic soft_rst;

  assign ctl_rise = edges.rise[0];
  assign ref_rise = edges.rise[1];
  assign req_en   = edges.level[2];
  assign req_inc  = edges.level[3];
  assign can_take = (q.st == ST_IDLE) || (q.st == ST_DONE);
  assign bus_req  = wb_cyc_i && wb_stb_i && !q.ack;
  assign soft_rst = bus_req && wb_we_i && (wb_adr_i == VPSC_ADR_CTRL) &&
                    wb_sel_i[0] && wb_dat_i[VPSC_CTRL_RST_BIT];

  always_comb
  begin
    next_q       = q;
    next_q.ack   = bus_req;
    next_q.limit = vpsc_step_limit(q.period);
    if (ctl_rise)
    begin
      case (q.st)
        ST_IDLE, ST_DONE:
        begin
          next_q.done = 1'b0;
          next_q.st   = ST_IDLE;
          if (req_en)
          begin
            next_q.st      = ST_REF;
            next_q.ref_cnt = '0;
            next_q.ctl_cnt = '0;
            if (req_inc && (q.count < $signed(q.limit)))
            begin
              next_q.count = q.count + 16'sh0001;
            end
            else if (!req_inc && (q.count > -$signed(q.limit)))
            begin
              next_q.count = q.count - 16'sh0001;
            end
          end
        end
        ST_CTRL:
        begin
          next_q.ctl_cnt = q.ctl_cnt + 2'h1;
          if (q.ctl_cnt == VPSC_CTRL_LAT - 2'h1)
          begin
            next_q.st   = ST_DONE;
            next_q.done = 1'b1;
          end
        end
        default:
        begin
          next_q.st = q.st; // pending: request ignored
        end
      endcase
    end
    if ((q.st == ST_REF) && ref_rise)
    begin
      next_q.ref_cnt = q.ref_cnt + 7'h01;
      if (q.ref_cnt == VPSC_REF_LAT - 7'h01)
      begin
        next_q.st = ST_CTRL;
      end
    end
    if (bus_req)
    begin
      next_q.rdata = '0;
      if (wb_we_i && (wb_adr_i == VPSC_ADR_PERIOD))
      begin
        if (wb_sel_i[0])
        begin
          next_q.period[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
          next_q.period[15:8] = wb_dat_i[15:8];
        end
      end
      else if (!wb_we_i)
      begin
        case (wb_adr_i)
          VPSC_ADR_PERIOD: next_q.rdata[15:0] = q.period;
          VPSC_ADR_LIMIT:  next_q.rdata[15:0] = q.limit;
          VPSC_ADR_STATUS:
          begin
            next_q.rdata[15:0]            = q.count;
            next_q.rdata[VPSC_STAT_PEND]  = !can_take;
            next_q.rdata[VPSC_STAT_DONE]  = q.done;
          end
          default: next_q.rdata = '0;
        endcase
      end
    end
    // software reset acts like the unit reset; bus state survives
    if (soft_rst)
    begin
      next_q.st    = ST_IDLE;
      next_q.count = '0;
      next_q.done  = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q        <= '0;
      q.period <= VPSC_PERIOD_RST;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign wb_ack_o           = q.ack;
  assign wb_dat_o           = q.rdata;
  assign shift_complete_o   = q.done;
  assign phase_step_count_o = q.count;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_inc_step: assert property (
      ctl_rise && can_take && req_en && req_inc &&
      q.count < $signed(q.limit) && !soft_rst |=>
      q.count == $past(q.count) + 16'sh0001)
    else $error("increment lost");
  a_dec_step: assert property (
      ctl_rise && can_take && req_en && !req_inc &&
      q.count > -$signed(q.limit) && !soft_rst |=>
      q.count == $past(q.count) - 16'sh0001)
    else $error("decrement lost");
  // soft reset may zero the count in the same cycle
  a_limit_hold: assert property (
      ctl_rise && can_take && req_en && req_inc &&
      q.count >= $signed(q.limit) && !soft_rst |=> $stable(q.count))
    else $error("count passed limit");
  a_busy_ignore: assert property (
      !can_take && !soft_rst |=> $stable(q.count))
    else $error("request taken while pending");
  a_ref_wait: assert property (
      q.st == ST_REF && ref_rise && q.ref_cnt == 7'h63 && !soft_rst |=>
      q.st == ST_CTRL)
    else $error("reference wait wrong");
  a_done_cause: assert property (
      $rose(q.done) |-> $past(q.st) == ST_CTRL && $past(q.ctl_cnt) == 2'h2)
    else $error("completion without wait");
  a_done_once: assert property (
      q.done && ctl_rise |=> !q.done)
    else $error("completion longer than one cycle");
  // 20 ns is below 60 MHz: scale 10 times 17 ns
  a_limit_calc: assert property (
      q.period == 16'h4E20 |=> q.limit == 16'h00AA)
    else $error("step limit wrong");
  a_soft_zero: assert property (
      soft_rst |=> q.count == 16'sh0000 && q.st == ST_IDLE)
    else $error("reset left a shift");
  a_bus_ack: assert property (
      wb_cyc_i && wb_stb_i && !q.ack |=> q.ack ##1 !q.ack)
    else $error("ack not single");

  c_inc: cover property (ctl_rise && can_take && req_en && req_inc);
  c_dec: cover property (ctl_rise && can_take && req_en && !req_inc);
  c_sat: cover property (ctl_rise && can_take && req_en &&
    q.count == $signed(q.limit));
  c_done: cover property ($rose(q.done));
endmodule // vpsc_ctrl

// file: src/vpsc_edge_if.sv
/*
  Carrier between the input synchroniser and the controller:
  synchronised levels and rising edge strobes of sampled clocks.
  Assumes both ends run on clk_i.
*/
`timescale 1ns/1ps
interface vpsc_edge_if #(
  parameter int W    = 4,
  parameter int NCLK = 2
);
  logic [W-1:0]    level;
  logic [NCLK-1:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// file: src/vpsc_pkg.sv
/*
  Constants, register map and the sequencing states of the variable
  phase shift controller.
  Assumes a 125 MHz system clock and byte addressed Wishbone offsets.
*/
package vpsc_pkg;

  // register byte offsets
  localparam logic [7:0]  VPSC_ADR_CTRL     = 8'h00;
  localparam logic [7:0]  VPSC_ADR_PERIOD   = 8'h04;
  localparam logic [7:0]  VPSC_ADR_STATUS   = 8'h08;
  localparam logic [7:0]  VPSC_ADR_LIMIT    = 8'h0C;

  // field positions
  localparam int          VPSC_CTRL_RST_BIT = 0;
  localparam int          VPSC_STAT_PEND    = 16;
  localparam int          VPSC_STAT_DONE    = 17;

  // reference clock period in ps, reset value 20000 ps
  localparam logic [15:0] VPSC_PERIOD_RST   = 16'h4E20;

  // step limit: scale * (period - 3 ns), scale chosen at 60 MHz
  localparam int          VPSC_FLOOR_PS     = 3000;
  localparam int          VPSC_SPLIT_MHZ    = 60;
  localparam int          VPSC_SLOW_PS      =
    (1000000 + VPSC_SPLIT_MHZ - 1) / VPSC_SPLIT_MHZ;
  localparam int          VPSC_SLOW_SCALE   = 10;
  localparam int          VPSC_FAST_SCALE   = 15;
  localparam int          VPSC_PS_PER_NS    = 1000;

  // settle latency: reference cycles, then control cycles
  localparam logic [6:0]  VPSC_REF_LAT      = 7'h64;
  localparam logic [1:0]  VPSC_CTRL_LAT     = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REF  = 2'b01,
    ST_CTRL = 2'b10,
    ST_DONE = 2'b11
  } vpsc_state_e;

  function automatic logic [15:0] vpsc_step_limit(input logic [15:0] per);
    int d;
    int s;
    d = int'(per) - VPSC_FLOOR_PS;
    s = (int'(per) >= VPSC_SLOW_PS) ? VPSC_SLOW_SCALE : VPSC_FAST_SCALE;
    if (d < 0)
    begin
      d = 0;
    end
    vpsc_step_limit = 16'((s * d) / VPSC_PS_PER_NS);
  endfunction

endpackage

// file: src/vpsc_sync.sv
/*
  Two flop synchroniser for a group of foreign inputs, plus a third
  stage that gives the level just before each detected clock edge.
  Assumes the low NCLK bits are clocks slower than half of clk_i.
*/
`timescale 1ns/1ps
module vpsc_sync #(
  parameter int W    = 4,
  parameter int NCLK = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  vpsc_edge_if.src          edge_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } vpsc_sync_s;

  vpsc_sync_s q;
  vpsc_sync_s next_q;

  always_comb
  begin
    next_q    = q;
    next_q.s1 = async_i;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  // data is taken from s3: the value standing before the edge
  assign edge_o.level = q.s3;

  genvar g;
  generate
    for (g = 0; g < NCLK; g++)
    begin : g_rise
      assign edge_o.rise[g] = q.s2[g] & ~q.s3[g];
    end
  endgenerate
endmodule // vpsc_sync

// file: verif/vpsc_ctrl_bench.sv
/*
  self-checking bench of the phase shift controller; drivers note
  expected values, a watcher compares them as results appear.
  assumes the user model drives the control side.
*/
`timescale 1ns/1ps
module vpsc_ctrl_bench;
  import vpsc_pkg::*;
  typedef struct {
    string       n;
    logic [31:0] v;
  } vpsc_exp_s;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ref_clk = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0]  sel = 4'h0;
  // byte lanes used by the next bus access
  logic [3:0]  sm = 4'hF;
  logic [31:0] rdat;
  logic        ack;
  logic        sck;
  logic        sen;
  logic        sdir;
  logic        done;
  logic [15:0] cnt;
  logic        done_q = 1'b0;
  logic [31:0] seed = 32'h590B4AA9;
  logic [31:0] r;
  int          n_errors = 0;
  int          checks = 0;
  int          exp_cnt = 0;
  int          lim = 32'hAA;
  int          per[3] = '{32'h411A, 32'h411B, 32'h0C1C};
  int          lm[3] = '{32'hCC, 32'h88, 32'h1};
  vpsc_exp_s   rq[$];
  vpsc_exp_s   cq[$];
  vpsc_exp_s   e;

  initial forever #4 clk_i = ~clk_i;
  initial
  begin
    #3;
    forever #10 ref_clk = ~ref_clk;
  end

  vpsc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .shift_ctrl_clock_i(sck), .reference_clock_in_i(ref_clk),
    .shift_request_enable_i(sen), .shift_direction_i(sdir),
    .shift_complete_o(done), .phase_step_count_o(cnt));
  vpsc_user_model user (.shift_complete_i(done),
    .shift_ctrl_clock_o(sck), .shift_request_enable_o(sen),
    .shift_direction_o(sdir));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string n, input logic [31:0] seen,
                       input logic [31:0] ex);
    checks++;
    if (seen !== ex)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, ex, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= sm;
    do
      @(posedge clk_i);
    while (ack !== 1'b1 && ++t < 50);
    if (t >= 50)
      check("ack", 32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                    input string n);
    rq.push_back('{n, ex});
    wb(1'b0, a, 32'h0);
  endtask

  // count moves at acceptance, clipped at the step limit
  task automatic stp(input logic dir, input int hold);
    int   lat;
    logic one;
    if (dir && exp_cnt < lim)
      exp_cnt++;
    else if (!dir && exp_cnt > -lim)
      exp_cnt--;
    cq.push_back('{"step_count", 32'(exp_cnt)});
    user.step(dir, hold, lat, one);
    check("latency", 32'(lat >= 26 && lat <= 30), 32'h1);
    check("one_pulse", 32'(one), 32'h1);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && !we && rq.size() > 0)
    begin
      e = rq.pop_front();
      check(e.n, rdat, e.v);
    end
    if (done === 1'b1 && !done_q)
    begin
      if (cq.size() > 0)
      begin
        e = cq.pop_front();
        check(e.n, 32'(signed'(cnt)), e.v);
      end
      else
        check("spare_complete", 32'h0, 32'h1);
    end
    done_q <= (done === 1'b1);
  end

  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    end_of_test;
  end

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    r = xs();
    rd(VPSC_ADR_PERIOD, 32'(VPSC_PERIOD_RST), "period");
    rd(VPSC_ADR_LIMIT, 32'hAA, "limit");
    wb(1'b1, VPSC_ADR_LIMIT, r);
    rd(VPSC_ADR_LIMIT, 32'hAA, "limit_ro");
    rd({2'b01, r[5:2], 2'b00}, 32'h0, "unmapped");
    $display("test 1 done");
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      stp(r[0], 1);
    end
    // status seen while pending, then in the completion cycle
    fork
      stp(1'b1, 2);
      begin
        repeat (40) @(posedge clk_i);
        rd(VPSC_ADR_STATUS, {14'h0, 2'b01, 16'(exp_cnt)}, "pending");
        while (done !== 1'b1)
          @(posedge clk_i);
        rd(VPSC_ADR_STATUS, {14'h0, 2'b10, 16'(exp_cnt)}, "complete");
      end
    join
    rd(VPSC_ADR_STATUS, {16'h0000, 16'(exp_cnt)}, "status");
    $display("test 2 done");
    // upper byte lane only: the low byte must survive
    sm = 4'h2;
    wb(1'b1, VPSC_ADR_PERIOD, 32'h00004100);
    sm = 4'hF;
    rd(VPSC_ADR_PERIOD, 32'h00004120, "period_lane");
    rd(VPSC_ADR_LIMIT, 32'h00000088, "limit_lane");
    foreach (per[i])
    begin
      wb(1'b1, VPSC_ADR_PERIOD, 32'(per[i]));
      rd(VPSC_ADR_LIMIT, 32'(lm[i]), "limit");
    end
    wb(1'b1, VPSC_ADR_CTRL, 32'h1);
    exp_cnt = 0;
    lim = 1;
    rd(VPSC_ADR_STATUS, 32'h0, "soft_reset");
    for (int i = 0; i < 5; i++)
      stp(i < 2, 1);
    $display("test 3 done");
    // hard reset while the count sits at minus one
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    exp_cnt = 0;
    repeat (4) @(posedge clk_i);
    rd(VPSC_ADR_STATUS, 32'h0, "hard_reset");
    rd(VPSC_ADR_LIMIT, 32'hAA, "limit");
    repeat (2) @(posedge clk_i);
    check("queues", 32'(rq.size() + cq.size()), 32'h0);
    $display("test 4 done");
    end_of_test;
  end
endmodule // vpsc_ctrl_bench

// file: verif/vpsc_user_model.sv
/*
  user logic model: runs the control clock and issues phase steps.
  assumes the controller samples this clock with its own clock.
*/
`timescale 1ns/1ps
module vpsc_user_model (
  input  wire logic shift_complete_i,
  output logic      shift_ctrl_clock_o,
  output logic      shift_request_enable_o,
  output logic      shift_direction_o
);
  initial
  begin
    shift_ctrl_clock_o     = 1'b0;
    shift_request_enable_o = 1'b0;
    shift_direction_o      = 1'b0;
    #37;
    forever #40 shift_ctrl_clock_o = ~shift_ctrl_clock_o;
  end

  // hold above 1 keeps enable up while pending, which must be ignored
  task automatic step(input logic dir, input int hold,
                      output int lat, output logic one);
    @(posedge shift_ctrl_clock_o);
    shift_request_enable_o <= 1'b1;
    shift_direction_o      <= dir;
    repeat (hold) @(posedge shift_ctrl_clock_o);
    shift_request_enable_o <= 1'b0;
    // inverted so a stale direction cannot pass by luck
    shift_direction_o      <= ~dir;
    lat = hold - 1;
    do
    begin
      @(posedge shift_ctrl_clock_o);
      lat++;
    end
    while (shift_complete_i !== 1'b1 && lat < 60);
    @(posedge shift_ctrl_clock_o);
    one = (shift_complete_i === 1'b0);
  endtask
endmodule // vpsc_user_model
